// >>> logic/hbs_pkg.sv
// package: states, constants and carrier structs for the hub boot sequencer
package hbs_pkg;

  // =====================================================
  // spi flash layout and timing
  localparam logic [15:0] HBS_SIG_ADDR = 16'hfffa;
  localparam logic [15:0] HBS_EXEC_ADDR = 16'h0000;
  localparam logic [31:0] HBS_SIG_WORD = 32'h32444655;
  localparam int HBS_SIG_BYTES = 4;
  localparam int HBS_ROM_KBIT = 1024;
  localparam int HBS_SPI_SLOW_MHZ = 30;
  localparam int HBS_SPI_FAST_MHZ = 60;
  localparam logic HBS_RATE_SLOW = 1'b0;
  localparam logic HBS_RATE_FAST = 1'b1;
  localparam logic [7:0] HBS_CFG_DONE_REG = 8'hff;

  // =====================================================
  // hardware init timing
  localparam int HBS_CLK_MHZ = 20;
  localparam int HBS_REG_SETTLE_NS = 1000;
  localparam int HBS_REG_SETTLE_CYC = (HBS_REG_SETTLE_NS * HBS_CLK_MHZ + 999) / 1000;
  localparam int HBS_CNT_W = 8;
  localparam int HBS_REF_SEEN_MIN = 4;
  // probe dwell: covers line settling plus the two synchroniser stages
  localparam logic [1:0] HBS_PROBE_CYC = 2'h3;

  // =====================================================
  // sequencer states
  typedef enum logic [3:0] {
    HBS_STANDBY,
    HBS_HARDWARE_SETUP_STAGE,
    HBS_FIRMWARE_SETUP_STAGE,
    HBS_SMBUS_PROBE,
    HBS_SOC_CONFIG,
    HBS_MERGE,
    HBS_IDLE,
    HBS_SUSPEND,
    HBS_CHARGER_DETECT_STAGE,
    HBS_HUB_CONNECT,
    HBS_NORMAL
  } hbs_state_t;

  // flash reader commands and results
  typedef struct packed {
    logic start;
    logic dual;
    logic fast;
    logic [15:0] addr;
  } hbs_flash_req_t;

  typedef struct packed {
    logic done;
    logic sig_ok;
  } hbs_flash_rsp_t;

  // settings applied to hardware after merge
  typedef struct packed {
    logic chg_det_en;
    logic keep_awake_in_suspend;
    logic spi_rate_strap;
  } hbs_cfg_t;

  // increment helper for the bit, settle and edge counters
  function automatic logic [HBS_CNT_W-1:0] hbs_inc(input logic [HBS_CNT_W-1:0] v);
    hbs_inc = v + {{(HBS_CNT_W-1){1'b0}}, 1'b1};
  endfunction

endpackage

// >>> logic/hbs_sync.sv
// two-flop synchroniser for a bundle of pin levels
`timescale 1ns/100ps
module hbs_sync #(
  parameter int W = 1
) (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  logic [W-1:0] meta_reg;

  // first stage feeds only the second
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      meta_reg <= '0;
      q <= '0;
    end else begin
      meta_reg <= d;
      q <= meta_reg;
    end
  end
endmodule

// >>> logic/hbs_flash_sig.sv
// spi flash signature reader, single or dual bit, mode 0 timing
`timescale 1ns/100ps
module hbs_flash_sig
  import hbs_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rst,
  input hbs_flash_req_t req,
  input wire logic miso0,
  input wire logic miso1,
  output hbs_flash_rsp_t rsp,
  output logic spi_clk,
  output logic spi_cs_n,
  output logic spi_mosi
);
  localparam logic [7:0] CMD_RD = 8'h03;
  localparam logic [7:0] CMD_RD2 = 8'h3b;
  logic busy_reg;
  logic [7:0] bit_reg;
  logic [39:0] sh_reg;
  logic [31:0] rx_reg;
  logic dual_reg;
  logic [7:0] last;

  // header bits 32, dummy 8 for dual, data 32 bits
  assign last = dual_reg ? 8'd56 : 8'd64;

  // transfer sequencing: clock toggles, sample on rising edge
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      busy_reg <= 1'b0;
      bit_reg <= '0;
      sh_reg <= '0;
      rx_reg <= '0;
      dual_reg <= 1'b0;
      spi_clk <= 1'b0;
      spi_cs_n <= 1'b1;
      spi_mosi <= 1'b0;
      rsp <= '0;
    end else begin
      rsp.done <= 1'b0;
      if (req.start && !busy_reg) begin
        busy_reg <= 1'b1;
        dual_reg <= req.dual;
        bit_reg <= '0;
        sh_reg <= {(req.dual ? CMD_RD2 : CMD_RD), 8'h00, req.addr, 8'h00};
        spi_cs_n <= 1'b0;
        spi_mosi <= 1'b0;
      end else if (busy_reg) begin
        spi_clk <= ~spi_clk;
        if (!spi_clk) begin
          // rising edge: sample data
          if (bit_reg >= 8'd32 + (dual_reg ? 8'd8 : 8'd0))
            rx_reg <= dual_reg ? {rx_reg[29:0], miso1, miso0} : {rx_reg[30:0], miso1};
          bit_reg <= hbs_inc(bit_reg);
        end else begin
          // falling edge: shift next command bit out
          spi_mosi <= sh_reg[39];
          sh_reg <= {sh_reg[38:0], 1'b0};
          if (bit_reg == last) begin
            busy_reg <= 1'b0;
            spi_cs_n <= 1'b1;
            spi_clk <= 1'b0;
            rsp.done <= 1'b1;
            rsp.sig_ok <= (rx_reg == HBS_SIG_WORD);
          end
        end
      end
    end
  end
endmodule

// >>> logic/hbs_boot_seq.sv
// hub boot mode sequencer: standby through normal operation
`timescale 1ns/100ps

// How it works
// R1: reset low holds standby, pins released, regulators off
// R2: reset high runs the hub mode sequence
// R3: all settings except the strap latches cleared while in standby
// R4: hardware setup enables core regulator, latches straps
// R5: smbus ignored during hardware setup
// R6: hardware setup waits for reference clock presence
// R7: read signature at 0xfffa, run flash at 0x0000
// R8: bad signature keeps internal rom execution
// R9: 1 Mbit rom clocked at half clk_sys; strap rate only drives spi_fast
// R10: single and dual bit reads supported
// R11: mode 0 and mode 3 flash both work
// R12: weak pull-downs probe smbus pull-ups
// R13: controller may rewrite defaults during configuration
// R14: wait forever until register 0xff written
// R15: merge defaults, controller writes, otp, then apply
// R16: idle then suspend without vbus or connect
// R17: vbus goes to charger detect or connect
// R18: charger detection runs then hub connect
// R19: normal operation until reset drops
// R20: soft disconnect holds hub connect stage
// R21: no smbus service in usb suspend
// R22: keep-awake bit keeps smbus alive in suspend
// R23: no rom and no smbus uses defaults, straps
// R24: strap 0 gives 30 MHz, 1 gives 60 MHz
// R25: one encoded state machine on core clock
module hbs_boot_seq
  import hbs_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic chip_reset_n,
  input wire logic reference_clock_in,
  input wire logic pll_locked,
  input wire logic regulator_good,
  input wire logic spi_rate_strap,
  input wire logic spi_dual_strap,
  input wire logic spi_miso0,
  input wire logic spi_miso1,
  input wire logic smb_clk_in,
  input wire logic smb_dat_in,
  input wire logic smb_cfg_write,
  input wire logic [7:0] smb_cfg_addr,
  input wire logic smb_chg_det_en,
  input wire logic smb_keep_awake,
  input wire logic otp_valid,
  input wire logic otp_chg_det_en,
  input wire logic vbus_present,
  input wire logic hub_connect_req,
  input wire logic usb_suspend,
  input wire logic soft_disconnect,
  input wire logic chg_det_done,
  output logic core_reg_en,
  output logic pll_en,
  output logic pads_enable,
  output logic smb_pulldown_en,
  output logic smb_service_en,
  output logic spi_clk,
  output logic spi_cs_n,
  output logic spi_mosi,
  output logic spi_fast,
  output logic ext_rom_en,
  output logic [15:0] exec_addr,
  output logic chg_det_start,
  output logic hub_attach,
  output logic cfg_applied,
  output logic chg_det_en_out,
  output logic keep_awake_out,
  output logic in_suspend,
  output logic [3:0] stage
);
  // =====================================================
  // pin synchronisers
  logic [6:0] raw_pins;
  logic [6:0] sy;
  logic rst_n_s, ref_s, smb_c_s, smb_d_s, vbus_s, susp_s, sdisc_s;

  assign raw_pins = {chip_reset_n, reference_clock_in, smb_clk_in, smb_dat_in,
                     vbus_present, usb_suspend, soft_disconnect};
  assign {rst_n_s, ref_s, smb_c_s, smb_d_s, vbus_s, susp_s, sdisc_s} = sy;

  hbs_sync #(.W(7)) u_sync (
    .clk_sys(clk_sys),
    .rst(rst),
    .d(raw_pins),
    .q(sy)
  );

  // =====================================================
  // state and bookkeeping
  hbs_state_t state_reg, state_next;
  logic [HBS_CNT_W-1:0] settle_reg;
  logic [HBS_CNT_W-1:0] ref_seen_reg;
  logic ref_d_reg;
  logic straps_rate_reg, straps_dual_reg;
  logic soc_wr_reg, soc_chg_reg, soc_awake_reg;
  hbs_cfg_t cfg_reg;
  hbs_flash_req_t freq;
  hbs_flash_rsp_t frsp;
  logic flash_issued_reg;
  logic probe_wait;
  logic [1:0] probe_cnt_reg;
  logic hw_ready;
  logic ref_present;

  assign ref_present = (ref_seen_reg >= HBS_CNT_W'(HBS_REF_SEEN_MIN));
  assign hw_ready = (settle_reg >= HBS_CNT_W'(HBS_REG_SETTLE_CYC)) && pll_locked
                    && regulator_good && ref_present;

  // =====================================================
  // next state
  always_comb begin
    state_next = state_reg;
    case (state_reg)
      HBS_STANDBY:
        if (rst_n_s) state_next = HBS_HARDWARE_SETUP_STAGE; // R2 R4
      HBS_HARDWARE_SETUP_STAGE:
        if (hw_ready) state_next = HBS_FIRMWARE_SETUP_STAGE; // R6
      HBS_FIRMWARE_SETUP_STAGE:
        if (frsp.done) state_next = frsp.sig_ok ? HBS_MERGE : HBS_SMBUS_PROBE; // R7 R8
      HBS_SMBUS_PROBE:
        if (probe_wait) begin
          // pulled high against pull-downs means bus present
          state_next = (smb_c_s && smb_d_s) ? HBS_SOC_CONFIG : HBS_MERGE; // R12 R23
        end
      HBS_SOC_CONFIG:
        if (smb_cfg_write && smb_cfg_addr == HBS_CFG_DONE_REG) state_next = HBS_MERGE; // R14
      HBS_MERGE:
        state_next = HBS_IDLE; // R15
      HBS_IDLE: begin
        if (vbus_s) state_next = cfg_reg.chg_det_en ? HBS_CHARGER_DETECT_STAGE : HBS_HUB_CONNECT; // R17
        else if (!hub_connect_req) state_next = HBS_SUSPEND; // R16
      end
      HBS_SUSPEND:
        if (vbus_s || hub_connect_req) state_next = HBS_IDLE; // R16
      HBS_CHARGER_DETECT_STAGE:
        if (!cfg_reg.chg_det_en || chg_det_done) state_next = HBS_HUB_CONNECT; // R18
      HBS_HUB_CONNECT:
        if (!sdisc_s) state_next = HBS_NORMAL; // R20
      HBS_NORMAL:
        if (sdisc_s) state_next = HBS_HUB_CONNECT; // R20
      default:
        state_next = HBS_STANDBY;
    endcase
    if (!rst_n_s) state_next = HBS_STANDBY; // R1 R19
  end

  // state register held in standby by reset
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) state_reg <= HBS_STANDBY; // R25
    else state_reg <= state_next; // R25
  end

  // =====================================================
  // hardware setup: settle counter and reference clock detector
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      settle_reg <= '0;
      ref_seen_reg <= '0;
      ref_d_reg <= 1'b0;
    end else begin
      ref_d_reg <= ref_s;
      if (state_reg != HBS_HARDWARE_SETUP_STAGE) begin
        settle_reg <= '0;
        ref_seen_reg <= '0;
      end else begin
        if (settle_reg < HBS_CNT_W'(HBS_REG_SETTLE_CYC)) settle_reg <= hbs_inc(settle_reg);
        // count reference transitions; a few edges mean it is running
        if ((ref_s != ref_d_reg) && !ref_present) ref_seen_reg <= hbs_inc(ref_seen_reg); // R6
      end
    end
  end

  // strap latch on the last standby cycle, when reset release is seen
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      straps_rate_reg <= HBS_RATE_SLOW;
      straps_dual_reg <= 1'b0;
    end else if (state_reg == HBS_STANDBY && rst_n_s) begin
      straps_rate_reg <= spi_rate_strap; // R4 R24
      straps_dual_reg <= spi_dual_strap; // R10
    end
  end

  // =====================================================
  // firmware setup: flash signature read
  always_comb begin
    freq.start = (state_reg == HBS_FIRMWARE_SETUP_STAGE) && !flash_issued_reg; // R7
    freq.dual = straps_dual_reg; // R10
    freq.fast = straps_rate_reg; // R9 R24
    freq.addr = HBS_SIG_ADDR; // R7
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) flash_issued_reg <= 1'b0;
    else flash_issued_reg <= (state_reg == HBS_FIRMWARE_SETUP_STAGE);
  end

  // mode 0 reader; idle-low clock is also sampled correctly by mode 3 parts
  hbs_flash_sig u_flash (
    .clk_sys(clk_sys),
    .rst(rst),
    .req(freq),
    .miso0(spi_miso0),
    .miso1(spi_miso1),
    .rsp(frsp),
    .spi_clk(spi_clk),
    .spi_cs_n(spi_cs_n),
    .spi_mosi(spi_mosi)
  ); // R11

  // probe dwells until synchronised line levels reflect the pull-downs
  assign probe_wait = (probe_cnt_reg == HBS_PROBE_CYC); // R12
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      probe_cnt_reg <= '0;
    end else if (state_reg != HBS_SMBUS_PROBE) begin
      probe_cnt_reg <= '0;
    end else if (!probe_wait) begin
      probe_cnt_reg <= probe_cnt_reg + 2'h1;
    end
  end

  // =====================================================
  // controller writes captured during configuration only
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      soc_wr_reg <= 1'b0;
      soc_chg_reg <= 1'b0;
      soc_awake_reg <= 1'b0;
    end else if (state_reg == HBS_STANDBY) begin
      soc_wr_reg <= 1'b0; // R3
      soc_chg_reg <= 1'b0;
      soc_awake_reg <= 1'b0;
    end else if (state_reg == HBS_SOC_CONFIG && smb_cfg_write) begin
      soc_wr_reg <= 1'b1; // R13
      soc_chg_reg <= smb_chg_det_en;
      soc_awake_reg <= smb_keep_awake; // R22
    end
  end

  // merge: controller over otp over defaults
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      cfg_reg <= '0;
      ext_rom_en <= 1'b0;
      exec_addr <= HBS_EXEC_ADDR;
    end else if (state_reg == HBS_STANDBY) begin
      cfg_reg <= '0; // R3
      ext_rom_en <= 1'b0;
      exec_addr <= HBS_EXEC_ADDR;
    end else begin
      if (state_reg == HBS_FIRMWARE_SETUP_STAGE && frsp.done) begin
        ext_rom_en <= frsp.sig_ok; // R7 R8
        exec_addr <= HBS_EXEC_ADDR;
      end
      if (state_reg == HBS_MERGE) begin
        cfg_reg.chg_det_en <= soc_wr_reg ? soc_chg_reg : (otp_valid ? otp_chg_det_en : 1'b1); // R15
        cfg_reg.keep_awake_in_suspend <= soc_wr_reg & soc_awake_reg; // R15
        cfg_reg.spi_rate_strap <= straps_rate_reg; // R23
      end
    end
  end

  // =====================================================
  // registered outputs
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      core_reg_en <= 1'b0;
      pll_en <= 1'b0;
      pads_enable <= 1'b0;
      smb_pulldown_en <= 1'b0;
      smb_service_en <= 1'b0;
      spi_fast <= 1'b0;
      chg_det_start <= 1'b0;
      hub_attach <= 1'b0;
      cfg_applied <= 1'b0;
      chg_det_en_out <= 1'b0;
      keep_awake_out <= 1'b0;
      in_suspend <= 1'b0;
      stage <= '0;
    end else begin
      core_reg_en <= (state_next != HBS_STANDBY); // R1 R4
      pll_en <= (state_next != HBS_STANDBY);
      pads_enable <= (state_next != HBS_STANDBY) && (state_next != HBS_HARDWARE_SETUP_STAGE); // R1
      smb_pulldown_en <= (state_next == HBS_SMBUS_PROBE); // R12
      // no service in standby, hw setup or suspend unless kept awake
      smb_service_en <= (state_next != HBS_STANDBY) && (state_next != HBS_HARDWARE_SETUP_STAGE)
                        && !(susp_s && !cfg_reg.keep_awake_in_suspend); // R5 R21 R22
      spi_fast <= (straps_rate_reg == HBS_RATE_FAST); // R24
      chg_det_start <= (state_next == HBS_CHARGER_DETECT_STAGE) && cfg_reg.chg_det_en; // R18
      hub_attach <= (state_next == HBS_NORMAL); // R19
      cfg_applied <= (state_reg == HBS_MERGE) || (cfg_applied && state_next != HBS_STANDBY); // R15
      chg_det_en_out <= cfg_reg.chg_det_en;
      keep_awake_out <= cfg_reg.keep_awake_in_suspend;
      in_suspend <= (state_next == HBS_SUSPEND) || (susp_s && state_next == HBS_NORMAL);
      stage <= state_next;
    end
  end
endmodule

// >>> verif/hbs_far_model.sv
// far side model: signature flash and smbus line pull-ups
`timescale 1ns/100ps
module hbs_far_model
  import hbs_pkg::*;
(
  input wire logic spi_clk,
  input wire logic spi_cs_n,
  input wire logic smb_pulldown_en,
  input wire logic sig_good,
  input wire logic pullups_fitted,
  output logic spi_miso0,
  output logic spi_miso1,
  output logic smb_clk_in,
  output logic smb_dat_in
);
  // =====================================================
  // flash: 8 command and 24 address bits, then 32 data bits
  int n = 0;
  logic [31:0] word;
  initial spi_miso1 = 1'b0;
  assign word = sig_good ? HBS_SIG_WORD : ~HBS_SIG_WORD;
  assign spi_miso0 = ~spi_miso1;
  // count rising clock edges within a frame
  always @(posedge spi_clk or posedge spi_cs_n) begin
    if (spi_cs_n) n <= 0;
    else n <= n + 1;
  end
  // data out on falling edge, garbage when idle
  always @(negedge spi_clk or posedge spi_cs_n) begin
    if (!spi_cs_n && n >= 32 && n < 64) spi_miso1 <= word[63-n];
    else spi_miso1 <= ~spi_miso1;
  end
  // =====================================================
  // smbus lines: board pull-ups win over weak pull-downs
  assign smb_clk_in = pullups_fitted | ~smb_pulldown_en;
  assign smb_dat_in = pullups_fitted | ~smb_pulldown_en;
endmodule

// >>> verif/hbs_boot_seq_sva.sv
// port assertions for the hub boot sequencer
`timescale 1ns/100ps
module hbs_boot_seq_sva
  import hbs_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic chip_reset_n,
  input wire logic pll_locked,
  input wire logic smb_cfg_write,
  input wire logic soft_disconnect,
  input wire logic usb_suspend,
  input logic core_reg_en,
  input logic pads_enable,
  input logic smb_pulldown_en,
  input logic smb_service_en,
  input logic chg_det_start,
  input logic hub_attach,
  input logic chg_det_en_out,
  input logic keep_awake_out,
  input logic [3:0] stage
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);
  // =====================================================
  // sequencing checks
  standby_hold_a: assert property (!chip_reset_n [*5] |-> stage == HBS_STANDBY && !core_reg_en && !pads_enable)
    else $error("standby not held");
  hw_quiet_a: assert property (stage == HBS_HARDWARE_SETUP_STAGE |-> !smb_service_en)
    else $error("smbus served in hardware setup");
  pll_gate_a: assert property (stage == HBS_FIRMWARE_SETUP_STAGE && $past(stage) == HBS_HARDWARE_SETUP_STAGE |-> $past(pll_locked))
    else $error("setup left without lock");
  probe_only_a: assert property (smb_pulldown_en |-> stage == HBS_SMBUS_PROBE || $past(stage) == HBS_SMBUS_PROBE)
    else $error("pull-downs outside probe");
  cfg_wait_a: assert property (stage == HBS_SOC_CONFIG && !smb_cfg_write && !$past(smb_cfg_write) |=> stage inside {HBS_SOC_CONFIG, HBS_STANDBY})
    else $error("config left without write");
  chg_route_a: assert property (stage == HBS_CHARGER_DETECT_STAGE && $past(stage) == HBS_CHARGER_DETECT_STAGE |-> chg_det_en_out && chg_det_start)
    else $error("charger stage wrongly used");
  soft_hold_a: assert property (soft_disconnect [*5] |-> stage != HBS_NORMAL)
    else $error("normal during soft disconnect");
  attach_when_a: assert property (hub_attach |-> stage == HBS_NORMAL || $past(stage) == HBS_NORMAL)
    else $error("attach outside normal");
  suspend_quiet_a: assert property ((usb_suspend && !keep_awake_out) [*6] |-> !smb_service_en)
    else $error("smbus served in suspend");
endmodule
bind hbs_boot_seq hbs_boot_seq_sva chk (.clk_sys, .rst, .chip_reset_n, .pll_locked, .smb_cfg_write, .soft_disconnect,
  .usb_suspend, .core_reg_en, .pads_enable, .smb_pulldown_en, .smb_service_en, .chg_det_start, .hub_attach,
  .chg_det_en_out, .keep_awake_out, .stage);

// >>> verif/testbench.sv
// self-checking bench for the hub boot sequencer
`timescale 1ns/100ps
module testbench;
  import hbs_pkg::*;
  logic clk_sys = 1'b0, rst = 1'b1, chip_reset_n = 1'b0, reference_clock_in = 1'b0, ref_on = 1'b0;
  logic pll_locked = 1'b1, regulator_good = 1'b1, spi_rate_strap = 1'b0, sig_good = 1'b0, pullups = 1'b0;
  logic smb_cfg_write = 1'b0, smb_chg_det_en = 1'b0, smb_keep_awake = 1'b0, vbus_present = 1'b0;
  logic usb_suspend = 1'b0, soft_disconnect = 1'b0, chg_det_done = 1'b0;
  logic [7:0] smb_cfg_addr = 8'h00;
  logic spi_miso0, spi_miso1, smb_clk_in, smb_dat_in, core_reg_en, pads_enable, smb_pulldown_en;
  logic smb_service_en, spi_clk, spi_cs_n, spi_fast, ext_rom_en, chg_det_start, hub_attach;
  logic cfg_applied, chg_det_en_out, keep_awake_out;
  logic [15:0] exec_addr;
  logic [3:0] stage;
  int errors = 0, n_checks = 0;
  // =====================================================
  // clock, reference clock, design and far side
  always #25 clk_sys = ~clk_sys;
  always @(negedge clk_sys) if (ref_on) reference_clock_in <= ~reference_clock_in;
  hbs_boot_seq dut (.clk_sys, .rst, .chip_reset_n, .reference_clock_in, .pll_locked, .regulator_good,
    .spi_rate_strap, .spi_dual_strap(1'b0), .spi_miso0, .spi_miso1, .smb_clk_in, .smb_dat_in, .smb_cfg_write,
    .smb_cfg_addr, .smb_chg_det_en, .smb_keep_awake, .otp_valid(1'b0), .otp_chg_det_en(1'b0), .vbus_present,
    .hub_connect_req(1'b0), .usb_suspend, .soft_disconnect, .chg_det_done, .core_reg_en, .pll_en(),
    .pads_enable, .smb_pulldown_en, .smb_service_en, .spi_clk, .spi_cs_n, .spi_mosi(), .spi_fast, .ext_rom_en,
    .exec_addr, .chg_det_start, .hub_attach, .cfg_applied, .chg_det_en_out, .keep_awake_out, .in_suspend(),
    .stage);
  hbs_far_model far (.spi_clk, .spi_cs_n, .smb_pulldown_en, .sig_good, .pullups_fitted(pullups), .spi_miso0,
    .spi_miso1, .smb_clk_in, .smb_dat_in);
  // =====================================================
  // tasks
  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    n_checks++;
    if (got !== exp) begin
      errors++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic wait_stage(input logic [3:0] s);
    for (int i = 0; i < 4000 && stage !== s; i++) @(negedge clk_sys);
    chk("stage", {12'h000, s}, {12'h000, stage});
  endtask
  task automatic boot(input logic rate, input logic good, input logic fit, input logic run);
    chip_reset_n = 1'b0;
    ref_on = 1'b0;
    repeat (8) @(negedge clk_sys);
    spi_rate_strap = rate;
    sig_good = good;
    pullups = fit;
    ref_on = run;
    chip_reset_n = 1'b1;
  endtask
  task automatic cfg_write(input logic [7:0] a, input logic chg, input logic awake);
    smb_cfg_addr = a;
    smb_chg_det_en = chg;
    smb_keep_awake = awake;
    smb_cfg_write = 1'b1;
    @(negedge clk_sys);
    smb_cfg_write = 1'b0;
  endtask
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  // =====================================================
  // watchdog
  initial begin
    repeat (30000) @(posedge clk_sys);
    errors++;
    tally_and_finish;
  end
  // =====================================================
  // tests
  initial begin
    repeat (16) @(negedge clk_sys);
    rst = 1'b0;
    repeat (10) @(negedge clk_sys);
    chk("spi_cs_n", 16'h0001, spi_cs_n);
    chk("standby", {12'h000, HBS_STANDBY}, stage);
    chk("core_reg_en", 16'h0000, core_reg_en);
    chk("pads_enable", 16'h0000, pads_enable);
    // good signature, fast strap, no reference clock at first
    boot(1'b1, 1'b1, 1'b0, 1'b0);
    wait_stage(HBS_HARDWARE_SETUP_STAGE);
    repeat (200) @(negedge clk_sys);
    chk("stuck in setup", {12'h000, HBS_HARDWARE_SETUP_STAGE}, stage);
    chk("core_reg_en", 16'h0001, core_reg_en);
    chk("smb_service_en", 16'h0000, smb_service_en);
    ref_on = 1'b1;
    wait_stage(HBS_FIRMWARE_SETUP_STAGE);
    spi_rate_strap = 1'b0;
    wait_stage(HBS_SUSPEND);
    chk("spi_fast", 16'h0001, spi_fast);
    chk("ext_rom_en", 16'h0001, ext_rom_en);
    chk("exec_addr", HBS_EXEC_ADDR, exec_addr);
    // bad signature, board pull-ups, controller configures
    boot(1'b0, 1'b0, 1'b1, 1'b1);
    wait_stage(HBS_SOC_CONFIG);
    chk("ext_rom_en", 16'h0000, ext_rom_en);
    chk("spi_fast", 16'h0000, spi_fast);
    cfg_write(8'h10, 1'b0, 1'b1);
    repeat (300) @(negedge clk_sys);
    chk("config wait", {12'h000, HBS_SOC_CONFIG}, stage);
    cfg_write(HBS_CFG_DONE_REG, 1'b0, 1'b1);
    wait_stage(HBS_SUSPEND);
    chk("cfg_applied", 16'h0001, cfg_applied);
    chk("chg_det_en_out", 16'h0000, chg_det_en_out);
    chk("keep_awake_out", 16'h0001, keep_awake_out);
    vbus_present = 1'b1;
    wait_stage(HBS_HUB_CONNECT);
    wait_stage(HBS_NORMAL);
    chk("hub_attach", 16'h0001, hub_attach);
    usb_suspend = 1'b1;
    repeat (10) @(negedge clk_sys);
    chk("awake smbus", 16'h0001, smb_service_en);
    usb_suspend = 1'b0;
    soft_disconnect = 1'b1;
    wait_stage(HBS_HUB_CONNECT);
    repeat (50) @(negedge clk_sys);
    chk("soft hold", {12'h000, HBS_HUB_CONNECT}, stage);
    soft_disconnect = 1'b0;
    wait_stage(HBS_NORMAL);
    chip_reset_n = 1'b0;
    wait_stage(HBS_STANDBY);
    repeat (3) @(negedge clk_sys);
    chk("keep_awake_out", 16'h0000, keep_awake_out);
    chk("cfg_applied", 16'h0000, cfg_applied);
    // no flash, no bus: defaults run charger detection
    boot(1'b0, 1'b0, 1'b0, 1'b1);
    wait_stage(HBS_CHARGER_DETECT_STAGE);
    chk("chg_det_start", 16'h0001, chg_det_start);
    chk("ext_rom_en", 16'h0000, ext_rom_en);
    chg_det_done = 1'b1;
    wait_stage(HBS_HUB_CONNECT);
    wait_stage(HBS_NORMAL);
    usb_suspend = 1'b1;
    repeat (10) @(negedge clk_sys);
    chk("suspend smbus", 16'h0000, smb_service_en);
    tally_and_finish;
  end
endmodule
